// ### design/dmb_pkg.sv
package dmb_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int BANK_W = 4;
    localparam int BUF_CNT = 6;
    // General-purpose RAM spans banks 0 to 12
    localparam int GPR_DEPTH = 3328;
    localparam logic [ADDR_W-1:0] GPR_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] GPR_TOP = 12'hCFF;
    // Peripheral register area, extended part below the special function area
    localparam logic [ADDR_W-1:0] PERIPH_BASE = 12'hD00;
    localparam logic [ADDR_W-1:0] SPECIAL_AREA_BASE = 12'hF80;
    localparam logic [ADDR_W-1:0] SPECIAL_AREA_TOP = 12'hFFF;
    localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK = 4'hF;
    localparam logic [BANK_W-1:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [DATA_W-1:0] ACCESS_SPLIT = 8'h80;
    localparam logic [DATA_W-1:0] INDEXED_SPLIT = 8'h60;
    // Registers held in this block
    localparam logic [ADDR_W-1:0] BANK_POINTER_ADDR = 12'hFE0;
    localparam logic [ADDR_W-1:0] BUFFER_DIRECTION_ADDR = 12'hF78;
    localparam logic [BANK_W-1:0] BANK_POINTER_RST = 4'h0;
    localparam logic [BUF_CNT-1:0] BUFFER_DIRECTION_RST = 6'h00;

    typedef enum logic [1:0] {
        DMB_RGN_NONE = 2'b00,
        DMB_RGN_GPR = 2'b01,
        DMB_RGN_PERIPH = 2'b11,
        DMB_RGN_LOCAL = 2'b10
    } dmb_region_e;

    // Forced access-bank map: low half in bank 0, high half in bank 15
    function automatic logic [ADDR_W-1:0] access_map(input logic [DATA_W-1:0] op);
        access_map = (op >= ACCESS_SPLIT) ? {ACCESS_HIGH_BANK, op} : {ACCESS_LOW_BANK, op};
    endfunction

    // Pointer access ports: five entries at the top of each 8-byte pointer group
    function automatic logic is_indirect(input logic [ADDR_W-1:0] a);
        is_indirect = (a == 12'hFEF) || (a == 12'hFEE) || (a == 12'hFED) || (a == 12'hFEC)
            || (a == 12'hFEB) || (a == 12'hFE7) || (a == 12'hFE6) || (a == 12'hFE5)
            || (a == 12'hFE4) || (a == 12'hFE3) || (a == 12'hFDF) || (a == 12'hFDE)
            || (a == 12'hFDD) || (a == 12'hFDC) || (a == 12'hFDB);
    endfunction

    // Registers present only on the larger-pin-count variants
    function automatic logic is_large_only(input logic [ADDR_W-1:0] a);
        is_large_only = (a == 12'hFBC) || (a == 12'hFBB) || (a == 12'hFBA) || (a == 12'hFB6)
            || (a == 12'hFB5) || (a == 12'hF96) || (a == 12'hF95) || (a == 12'hF8D)
            || (a == 12'hF8C) || (a == 12'hF84) || (a == 12'hF83);
    endfunction
endpackage

// ### design/dmb_acc_if.sv
interface dmb_acc_if;
    logic access_sel;
    logic [dmb_pkg::DATA_W-1:0] operand;
    logic full_valid;
    logic [dmb_pkg::ADDR_W-1:0] full_addr;
    logic [dmb_pkg::BANK_W-1:0] bank_pointer;
    logic extended_isa_config_bit;
    logic [dmb_pkg::ADDR_W-1:0] index_base;
    logic [dmb_pkg::ADDR_W-1:0] addr;

    modport core (output access_sel, output operand, output full_valid, output full_addr,
        output bank_pointer, output extended_isa_config_bit, output index_base, input addr);
    modport mapper (input access_sel, input operand, input full_valid, input full_addr,
        input bank_pointer, input extended_isa_config_bit, input index_base, output addr);
endinterface

// ### design/dmb_addr_map.sv
module dmb_addr_map (
    dmb_acc_if.mapper acc
);
    logic [dmb_pkg::ADDR_W-1:0] indexed_addr;

    assign indexed_addr = acc.index_base + {4'h0, acc.operand};

    always_comb begin
        if (acc.full_valid) begin
            acc.addr = acc.full_addr;
        end else if (acc.access_sel) begin
            acc.addr = {acc.bank_pointer, acc.operand};
        end else if (acc.extended_isa_config_bit && (acc.operand < dmb_pkg::INDEXED_SPLIT)) begin
            acc.addr = indexed_addr;
        end else begin
            acc.addr = dmb_pkg::access_map(acc.operand);
        end
    end
endmodule // dmb_addr_map

// ### design/dmb_gpr_ram.sv
module dmb_gpr_ram (
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [dmb_pkg::ADDR_W-1:0] i_addr,
    input wire logic [dmb_pkg::DATA_W-1:0] i_wdata,
    output logic [dmb_pkg::DATA_W-1:0] o_rdata
);
    logic [dmb_pkg::DATA_W-1:0] mem [dmb_pkg::GPR_DEPTH];
    logic [dmb_pkg::ADDR_W-1:0] idx;

    assign idx = (i_addr > dmb_pkg::GPR_TOP) ? dmb_pkg::GPR_BASE : i_addr;

    // No reset on storage: contents survive every reset
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[idx] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        o_rdata <= mem[idx];
    end
endmodule // dmb_gpr_ram

// ### design/dmb_bank_map.sv
module dmb_bank_map (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic i_access_sel,
    input wire logic [7:0] i_operand,
    input wire logic i_full_valid,
    input wire logic [11:0] i_full_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_extended_isa_config_bit,
    input wire logic [11:0] i_index_base,
    input wire logic i_large_variant,
    input wire logic [7:0] i_periph_rdata,
    input wire logic i_periph_hit,
    output logic o_rvalid,
    output logic [7:0] o_rdata,
    output logic [11:0] o_addr,
    output logic o_periph_re,
    output logic o_periph_we,
    output logic [7:0] o_periph_wdata,
    output logic o_indirect,
    output logic [5:0] o_buffer_tx_enable
);
    dmb_acc_if acc ();

    logic [3:0] bank_pointer;
    logic [5:0] buffer_direction_select;
    logic large_meta;
    logic large_sync;
    logic [11:0] map_addr;
    dmb_pkg::dmb_region_e next_region;
    logic variant_ok;
    logic ram_we;
    logic [7:0] ram_rdata;
    logic [7:0] next_local_rdata;
    logic s1_valid;
    logic s1_read;
    dmb_pkg::dmb_region_e s1_region;
    logic [7:0] s1_local_rdata;
    logic [7:0] next_rdata;

    assign acc.access_sel = i_access_sel;
    assign acc.operand = i_operand;
    assign acc.full_valid = i_full_valid;
    assign acc.full_addr = i_full_addr;
    assign acc.bank_pointer = bank_pointer;
    assign acc.extended_isa_config_bit = i_extended_isa_config_bit;
    assign acc.index_base = i_index_base;
    assign map_addr = acc.addr;

    // Address formation: full, banked, indexed or forced access map
    dmb_addr_map u_map (
        .acc(acc.mapper)
    );

    // Variant strap comes from a pin
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            large_meta <= 1'b0;
            large_sync <= 1'b0;
        end else begin
            large_meta <= i_large_variant;
            large_sync <= large_meta;
        end
    end

    assign variant_ok = !dmb_pkg::is_large_only(map_addr) || large_sync;

    // Region decode of the formed address
    always_comb begin
        if (map_addr <= dmb_pkg::GPR_TOP) begin
            next_region = dmb_pkg::DMB_RGN_GPR;
        end else if (map_addr == dmb_pkg::BANK_POINTER_ADDR || map_addr == dmb_pkg::BUFFER_DIRECTION_ADDR) begin
            next_region = dmb_pkg::DMB_RGN_LOCAL;
        end else if (variant_ok) begin
            next_region = dmb_pkg::DMB_RGN_PERIPH;
        end else begin
            next_region = dmb_pkg::DMB_RGN_NONE;
        end
    end

    assign ram_we = i_req_valid && i_req_write && (next_region == dmb_pkg::DMB_RGN_GPR);

    dmb_gpr_ram u_ram (
        .i_clk(i_clk),
        .i_we(ram_we),
        .i_addr(map_addr),
        .i_wdata(i_wdata),
        .o_rdata(ram_rdata)
    );

    // Bank pointer: only the low nibble is stored
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bank_pointer <= dmb_pkg::BANK_POINTER_RST;
        end else if (i_req_valid && i_req_write && map_addr == dmb_pkg::BANK_POINTER_ADDR) begin
            bank_pointer <= i_wdata[3:0];
        end
    end

    // Buffer direction select steers the programmable buffers
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            buffer_direction_select <= dmb_pkg::BUFFER_DIRECTION_RST;
        end else if (i_req_valid && i_req_write && map_addr == dmb_pkg::BUFFER_DIRECTION_ADDR) begin
            buffer_direction_select <= i_wdata[5:0];
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_buffer_tx_enable <= dmb_pkg::BUFFER_DIRECTION_RST;
        end else begin
            o_buffer_tx_enable <= buffer_direction_select;
        end
    end

    always_comb begin
        if (map_addr == dmb_pkg::BANK_POINTER_ADDR) begin
            next_local_rdata = {4'h0, bank_pointer};
        end else begin
            next_local_rdata = {2'b00, buffer_direction_select};
        end
    end

    // Stage 1: access presented to the peripheral side
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s1_valid <= 1'b0;
            s1_read <= 1'b0;
            s1_region <= dmb_pkg::DMB_RGN_NONE;
            s1_local_rdata <= 8'h00;
        end else begin
            s1_valid <= i_req_valid;
            s1_read <= i_req_valid && !i_req_write;
            s1_region <= next_region;
            s1_local_rdata <= next_local_rdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_addr <= 12'h000;
            o_periph_re <= 1'b0;
            o_periph_we <= 1'b0;
            o_periph_wdata <= 8'h00;
            o_indirect <= 1'b0;
        end else begin
            o_addr <= map_addr;
            o_periph_re <= i_req_valid && !i_req_write && next_region == dmb_pkg::DMB_RGN_PERIPH;
            o_periph_we <= i_req_valid && i_req_write && next_region == dmb_pkg::DMB_RGN_PERIPH;
            o_periph_wdata <= i_wdata;
            o_indirect <= i_req_valid && dmb_pkg::is_indirect(map_addr);
        end
    end

    // Read data select; missing locations return zero
    always_comb begin
        case (s1_region)
            dmb_pkg::DMB_RGN_GPR: next_rdata = ram_rdata;
            dmb_pkg::DMB_RGN_LOCAL: next_rdata = s1_local_rdata;
            dmb_pkg::DMB_RGN_PERIPH: next_rdata = i_periph_hit ? i_periph_rdata : 8'h00;
            default: next_rdata = 8'h00;
        endcase
    end

    // Stage 2: read answer, two cycles after every read request
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rvalid <= 1'b0;
            o_rdata <= 8'h00;
        end else begin
            o_rvalid <= s1_read;
            o_rdata <= s1_read ? next_rdata : 8'h00;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    chk_forced_low_map: assert property (
        i_req_valid && !i_full_valid && !i_access_sel && !i_extended_isa_config_bit && !i_operand[7]
        |-> ##1 o_addr == {4'h0, $past(i_operand)})
        else $error("Forced low operand not mapped into bank 0");

    chk_forced_high_map: assert property (
        i_req_valid && !i_full_valid && !i_access_sel && i_operand[7]
        |-> ##1 o_addr == {4'hF, $past(i_operand)})
        else $error("Forced high operand not mapped into bank 15");

    chk_banked_addr: assert property (
        i_req_valid && !i_full_valid && i_access_sel
        |-> ##1 o_addr == {$past(bank_pointer), $past(i_operand)})
        else $error("Banked address does not use bank pointer");

    chk_bank_ignored: assert property (
        i_req_valid && !i_full_valid && !i_access_sel && !i_extended_isa_config_bit
        |-> ##1 (o_addr[11:8] == 4'h0 || o_addr[11:8] == 4'hF))
        else $error("Forced access leaked the bank pointer");

    chk_read_latency: assert property (
        i_req_valid && !i_req_write |-> ##2 o_rvalid)
        else $error("Read answer not two cycles after request");

    chk_bank_upper_zero: assert property (
        i_req_valid && !i_req_write && map_addr == dmb_pkg::BANK_POINTER_ADDR
        |-> ##2 o_rvalid && o_rdata[7:4] == 4'h0 && o_rdata[3:0] == $past(bank_pointer, 2))
        else $error("Bank pointer read back wrong");

    chk_gpr_not_periph: assert property (
        s1_valid && o_addr <= dmb_pkg::GPR_TOP |-> !o_periph_re && !o_periph_we)
        else $error("RAM address reached peripheral side");

    chk_unused_zero: assert property (
        o_periph_re && !i_periph_hit |=> o_rvalid && o_rdata == 8'h00)
        else $error("Unimplemented location did not read zero");

    chk_variant_zero: assert property (
        i_req_valid && !i_req_write && dmb_pkg::is_large_only(map_addr) && !large_sync
        |-> ##1 !o_periph_re ##1 o_rdata == 8'h00)
        else $error("Larger-variant register visible on small variant");

    chk_indirect_no_ram: assert property (
        o_indirect |-> o_addr > dmb_pkg::GPR_TOP && s1_region != dmb_pkg::DMB_RGN_GPR)
        else $error("Pointer port backed by storage");

    chk_buffer_dir_out: assert property (
        i_req_valid && i_req_write && map_addr == dmb_pkg::BUFFER_DIRECTION_ADDR
        |-> ##2 o_buffer_tx_enable == $past(i_wdata[5:0], 2))
        else $error("Buffer transmit enables not updated");

    chk_indexed_map: assert property (
        i_req_valid && !i_full_valid && !i_access_sel && i_extended_isa_config_bit
        && i_operand < dmb_pkg::INDEXED_SPLIT
        |-> ##1 o_addr == $past(i_index_base) + {4'h0, $past(i_operand)})
        else $error("Extended access map not applied");

    chk_full_addr: assert property (
        i_req_valid && i_full_valid |-> ##1 o_addr == $past(i_full_addr))
        else $error("Full address not used directly");

    chk_answer_source: assert property (
        o_rvalid |-> $past(i_req_valid, 2) && !$past(i_req_write, 2))
        else $error("Read answer without a read request two cycles before");

    chk_idle_rdata: assert property (
        !o_rvalid |-> o_rdata == 8'h00)
        else $error("Read data not zero outside a read answer");

    chk_bank_load: assert property (
        i_req_valid && i_req_write && map_addr == dmb_pkg::BANK_POINTER_ADDR
        |=> bank_pointer == $past(i_wdata[3:0]))
        else $error("Bank pointer did not take the written low nibble");

    chk_bank_hold: assert property (
        !(i_req_valid && i_req_write && map_addr == dmb_pkg::BANK_POINTER_ADDR)
        |=> $stable(bank_pointer))
        else $error("Bank pointer changed without a write");

    chk_buffer_hold: assert property (
        !(i_req_valid && i_req_write && map_addr == dmb_pkg::BUFFER_DIRECTION_ADDR)
        |=> $stable(buffer_direction_select))
        else $error("Buffer direction select changed without a write");

    chk_periph_wdata: assert property (
        o_periph_we |-> o_periph_wdata == $past(i_wdata))
        else $error("Peripheral write data not the requested data");

    chk_periph_region: assert property (
        o_periph_re || o_periph_we
        |-> o_addr >= dmb_pkg::PERIPH_BASE && o_addr != dmb_pkg::BANK_POINTER_ADDR
        && o_addr != dmb_pkg::BUFFER_DIRECTION_ADDR)
        else $error("Peripheral strobe outside the peripheral area");

    chk_variant_drop: assert property (
        i_req_valid && i_req_write && dmb_pkg::is_large_only(map_addr) && !large_sync
        |=> !o_periph_we)
        else $error("Larger-variant register written on small variant");

    chk_local_quiet: assert property (
        s1_region == dmb_pkg::DMB_RGN_LOCAL |-> !o_periph_re && !o_periph_we)
        else $error("Local register access reached peripheral side");

    cov_forced_sfr_read: cover property (i_req_valid && !i_access_sel && i_operand[7] && !i_req_write ##2 o_rvalid);
    cov_banked_write: cover property (i_req_valid && i_access_sel && i_req_write && next_region == dmb_pkg::DMB_RGN_GPR);
    cov_bank_switch: cover property (i_req_valid && i_req_write && map_addr == dmb_pkg::BANK_POINTER_ADDR
        ##1 i_req_valid && i_access_sel);
    cov_indirect: cover property (o_indirect && o_periph_re);
    cov_indexed_read: cover property (i_req_valid && !i_full_valid && !i_access_sel && i_extended_isa_config_bit
        && i_operand < dmb_pkg::INDEXED_SPLIT);
endmodule // dmb_bank_map

// ### tb/dmb_periph_model.sv
module dmb_periph_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_re,
    input wire logic i_we,
    input wire logic [11:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic o_hit,
    output logic [7:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] regs [0:127];
    logic [7:0] last;
    logic impl;
    // Claim only used special function locations
    always_comb begin
        impl = (i_addr >= dmb_pkg::SPECIAL_AREA_BASE) && !(i_addr inside {12'hF9C, 12'hF9A, [12'hF97:12'hF99],
            [12'hF8E:12'hF91], [12'hF85:12'hF88], 12'hFD4, 12'hFB9});
        o_hit = i_re && impl;
        o_rdata = (i_re && impl) ? regs[i_addr[6:0]] : ~last;
    end
    // Released data bus shows the inverse of the last value
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            last <= 8'h00;
        end else if (i_re && impl) begin
            last <= regs[i_addr[6:0]];
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_we && impl) begin
            regs[i_addr[6:0]] <= i_wdata;
        end
    end
endmodule // dmb_periph_model

// ### tb/dmb_bank_map_tb_top.sv
module dmb_bank_map_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk, i_reset_n, i_req_valid, i_req_write, i_access_sel, i_full_valid, i_ext, i_large;
    logic [7:0] i_operand, i_wdata, p_rdata, o_rdata, o_periph_wdata, g_rd, g_wd;
    logic [11:0] i_full_addr, i_index_base, o_addr, g_addr;
    logic p_hit, o_rvalid, o_periph_re, o_periph_we, o_indirect, g_re, g_we, g_ind, g_rv;
    logic [5:0] o_buffer_tx_enable;
    logic [7:0] ops [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
    int n_fail = 0;
    int checks = 0;

    dmb_bank_map u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req_valid(i_req_valid),
        .i_req_write(i_req_write), .i_access_sel(i_access_sel), .i_operand(i_operand),
        .i_full_valid(i_full_valid), .i_full_addr(i_full_addr), .i_wdata(i_wdata),
        .i_extended_isa_config_bit(i_ext), .i_index_base(i_index_base), .i_large_variant(i_large),
        .i_periph_rdata(p_rdata), .i_periph_hit(p_hit), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
        .o_addr(o_addr), .o_periph_re(o_periph_re), .o_periph_we(o_periph_we),
        .o_periph_wdata(o_periph_wdata), .o_indirect(o_indirect), .o_buffer_tx_enable(o_buffer_tx_enable));
    dmb_periph_model u_periph (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_re(o_periph_re),
        .i_we(o_periph_we), .i_addr(o_addr), .i_wdata(o_periph_wdata), .o_hit(p_hit), .o_rdata(p_rdata));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    task automatic complete_run();
        if (n_fail == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One request, then capture the address-phase and read-phase answers
    task automatic acc(input logic wr, input logic sel, input logic fv, input logic [7:0] op,
        input logic [11:0] fa, input logic [7:0] wd);
        @(negedge i_clk);
        i_req_valid = 1'b1;
        i_req_write = wr;
        i_access_sel = sel;
        i_full_valid = fv;
        i_operand = op;
        i_full_addr = fa;
        i_wdata = wd;
        @(negedge i_clk);
        i_req_valid = 1'b0;
        g_addr = o_addr;
        g_re = o_periph_re;
        g_we = o_periph_we;
        g_ind = o_indirect;
        g_wd = o_periph_wdata;
        @(negedge i_clk);
        g_rv = o_rvalid;
        g_rd = o_rdata;
    endtask

    task automatic rd(input logic [11:0] fa);
        acc(1'b0, 1'b1, 1'b1, 8'hE0, fa, 8'h00);
    endtask

    initial begin
        #200000;
        n_fail++;
        complete_run();
    end

    initial begin
        {i_req_valid, i_req_write, i_access_sel, i_full_valid, i_ext, i_large} = 6'h00;
        i_operand = 8'h00;
        i_wdata = 8'h00;
        i_full_addr = 12'h000;
        i_index_base = 12'h200;
        i_reset_n = 1'b0;
        repeat (10) @(posedge i_clk);
        @(negedge i_clk);
        i_reset_n = 1'b1;
        acc(1'b0, 1'b0, 1'b0, 8'hE0, 12'h000, 8'h00);
        chk(g_addr, 12'hFE0);
        chk({g_rv, g_rd}, 12'h100);
        acc(1'b1, 1'b0, 1'b0, 8'hE0, 12'h000, 8'hA5);
        rd(12'hFE0);
        chk(g_rd, 8'h05);
        acc(1'b1, 1'b1, 1'b0, 8'h34, 12'h000, 8'h3C);
        chk(g_addr, 12'h534);
        chk({g_re, g_we}, 12'h000);
        rd(12'h534);
        chk(g_rd, 8'h3C);
        foreach (ops[k]) begin
            acc(1'b0, 1'b0, 1'b0, ops[k], 12'h000, 8'h00);
            chk(g_addr, {(ops[k] >= 8'h80) ? 4'hF : 4'h0, ops[k]});
        end
        // Bank pointer write followed at once by a banked access
        @(negedge i_clk);
        {i_req_valid, i_req_write, i_access_sel, i_full_valid} = 4'b1100;
        i_operand = 8'hE0;
        i_wdata = 8'h03;
        @(negedge i_clk);
        {i_req_write, i_access_sel} = 2'b01;
        i_operand = 8'h10;
        @(negedge i_clk);
        i_req_valid = 1'b0;
        chk(o_addr, 12'h310);
        acc(1'b1, 1'b0, 1'b0, 8'h7F, 12'h000, 8'h5A);
        acc(1'b1, 1'b0, 1'b1, 8'h00, 12'hCFF, 8'hC3);
        @(negedge i_clk);
        i_reset_n = 1'b0;
        @(negedge i_clk);
        i_reset_n = 1'b1;
        rd(12'h07F);
        chk(g_rd, 8'h5A);
        rd(12'hCFF);
        chk(g_rd, 8'hC3);
        rd(12'hFE0);
        chk(g_rd, 8'h00);
        acc(1'b1, 1'b0, 1'b0, 8'hC0, 12'h000, 8'h77);
        chk({g_we, g_addr}, 13'h1FC0);
        chk(g_wd, 8'h77);
        acc(1'b0, 1'b0, 1'b0, 8'hC0, 12'h000, 8'h00);
        chk({g_re, g_rv, g_rd}, 10'h377);
        acc(1'b1, 1'b0, 1'b1, 8'h00, 12'hF9C, 8'h99);
        rd(12'hF9C);
        chk({g_rv, g_rd}, 12'h100);
        acc(1'b1, 1'b0, 1'b1, 8'h00, 12'hD10, 8'h66);
        rd(12'hD10);
        chk({g_rv, g_rd}, 12'h100);
        acc(1'b1, 1'b0, 1'b1, 8'h00, 12'hFBC, 8'h44);
        rd(12'hFBC);
        chk(g_rd, 8'h00);
        i_large = 1'b1;
        repeat (3) @(posedge i_clk);
        acc(1'b1, 1'b0, 1'b1, 8'h00, 12'hFBC, 8'h44);
        rd(12'hFBC);
        chk(g_rd, 8'h44);
        acc(1'b0, 1'b0, 1'b0, 8'hEF, 12'h000, 8'h00);
        chk(g_ind, 1'b1);
        acc(1'b0, 1'b0, 1'b0, 8'hE8, 12'h000, 8'h00);
        chk(g_ind, 1'b0);
        acc(1'b1, 1'b0, 1'b1, 8'h00, 12'hF78, 8'hFF);
        chk(o_buffer_tx_enable, 6'h3F);
        acc(1'b1, 1'b0, 1'b1, 8'h00, 12'hF78, 8'h2A);
        chk(o_buffer_tx_enable, 6'h2A);
        rd(12'hF78);
        chk(g_rd, 8'h2A);
        i_ext = 1'b1;
        acc(1'b0, 1'b0, 1'b0, 8'h10, 12'h000, 8'h00);
        chk(g_addr, 12'h210);
        acc(1'b0, 1'b0, 1'b0, 8'h5F, 12'h000, 8'h00);
        chk(g_addr, 12'h25F);
        acc(1'b0, 1'b0, 1'b0, 8'h60, 12'h000, 8'h00);
        chk(g_addr, 12'h060);
        acc(1'b0, 1'b0, 1'b0, 8'h70, 12'h000, 8'h00);
        chk(g_addr, 12'h070);
        acc(1'b0, 1'b0, 1'b0, 8'h90, 12'h000, 8'h00);
        chk(g_addr, 12'hF90);
        i_index_base = 12'hFF8;
        acc(1'b0, 1'b0, 1'b0, 8'h10, 12'h000, 8'h00);
        chk(g_addr, 12'h008);
        i_ext = 1'b0;
        complete_run();
    end
endmodule // dmb_bank_map_tb_top
